// ===== shared/urx_pkg.sv
/*
 * Constants for the serial receiver: register map, field positions, reset values, timing counts and states.
 * Assumes a byte-addressed classic Wishbone bus with 32-bit data and one clock.
 */
package urx_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_WORD  = 8'h00;
    localparam logic [7:0] OFS_HOST_CTRL  = 8'h04;
    localparam logic [7:0] OFS_DIVISOR    = 8'h08;
    localparam logic [7:0] OFS_RX_BUFFER  = 8'h0c;
    localparam logic [7:0] OFS_FLAGS      = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;

    // ==========================================================
    // Control word fields
    localparam int CW_LEN_LO   = 0;
    localparam int CW_LEN_HI   = 1;
    localparam int CW_PAR_INH  = 2;
    localparam int CW_EVEN_PAR = 3;
    localparam int CW_STOP_SEL = 4;
    localparam int CW_LOAD     = 5;
    localparam int CW_WIDTH    = 5;

    // Host control, flag and interrupt fields
    localparam int HC_READY_CLEAR_N = 0;
    localparam int FL_DATA_READY    = 0;
    localparam int FL_OVERRUN       = 1;
    localparam int FL_FRAMING       = 2;
    localparam int FL_PARITY        = 3;
    localparam int EV_CHAR          = 0;
    localparam int EV_OVERRUN       = 1;
    localparam int EV_FRAMING       = 2;
    localparam int EV_PARITY        = 3;
    localparam int EV_WIDTH         = 4;

    // ==========================================================
    // Reset values
    localparam logic [CW_WIDTH-1:0] CW_RST      = 5'h00;
    localparam logic                LOAD_RST    = 1'b1;
    localparam logic                RCLR_N_RST  = 1'b1;
    localparam logic [15:0]         DIVISOR_RST = 16'h0043;
    localparam logic [EV_WIDTH-1:0] MASK_RST    = 4'h0;

    // ==========================================================
    // Timing counts in sample-clock ticks, and the shortest character length in data bits
    localparam logic [3:0] TICKS_PER_BIT = 4'hf;
    localparam logic [3:0] START_CENTRE  = 4'h7;
    localparam logic [3:0] MIN_LEN       = 4'h5;

    // ==========================================================
    // Receiver states, Gray coded along the frame
    typedef enum logic [2:0] {
        ST_HUNT   = 3'h0,
        ST_START  = 3'h1,
        ST_DATA   = 3'h3,
        ST_PARITY = 3'h2,
        ST_STOP   = 3'h6
    } urx_state_t;

endpackage : urx_pkg

// ===== shared/urx_tick_if.sv
/*
 * Link between the receiver core and its sample-clock divider.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/10ps

interface urx_tick_if;
    logic [15:0] divisor;
    logic        tick;

    modport core (output divisor, input  tick);
    modport gen  (input  divisor, output tick);
endinterface : urx_tick_if

// ===== src/urx_tick_gen.sv
/*
 * Divider that makes the one-cycle sample-clock enable at sixteen times the bit rate.
 * Assumes divisor is held stable by the core; period is divisor plus one clk_sys cycles.
 */
`timescale 1ns/10ps

module urx_tick_gen (
    input  wire logic clk_sys,
    input  wire logic reset,
    urx_tick_if.gen   tick_if
);

    logic [15:0] count_q;
    logic [15:0] count_d;
    logic        tick_q;
    logic        tick_d;

    // ==========================================================
    // Divider
    always_comb begin
        count_d = count_q + 16'h0001;
        tick_d  = 1'b0;
        if (count_q >= tick_if.divisor) begin
            count_d = 16'h0000;
            tick_d  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_q <= 16'h0000;
            tick_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q  <= tick_d;
        end
    end

    assign tick_if.tick = tick_q;

endmodule : urx_tick_gen

// ===== src/urx_receiver.sv
/*
 * Serial receiver with Wishbone register access, sticky interrupt status and mask.
 * Assumes rx_serial_in is synchronous to clk_sys and a classic Wishbone master.
 */
// Register access over Wishbone and the register addresses were chosen for this implementation.
// Notes on behaviour
// - Sample clock is sixteen times bit rate; one bit is sixteen ticks.
// - Low ready-clear level forces data-ready low.
// - Character moves into the receive buffer during the first stop bit.
// - Buffer bits above the character length read low.
// - First received bit lands in buffer bit zero, the lowest.
// - Overrun set when a transfer finds data-ready still set.
// - One tick after transfer, data-ready rises and framing is judged.
// - Framing flag set when the first stop bit samples low.
// - Parity flag set when enabled parity check fails.
// - Start detection may lag the line edge by one tick.
// - Start bit centre is sampled on the eighth tick after detection.
// - Hunting for the next start resumes at the stop bit centre.
// - Length select decodes to 5, 6, 7 or 8 data bits.
// - Parity inhibit skips checking and holds parity flag low.
// - Even-parity select high checks even, low checks odd.
// - Control word latched on falling edge of the load strobe.
`timescale 1ns/10ps

module urx_receiver (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_serial_in,
    output logic      [7:0]  rx_buffer,
    output logic             data_ready,
    output logic             overrun_flag,
    output logic             framing_flag,
    output logic             parity_flag,
    output logic             irq
);

    // ==========================================================
    // Helpers
    function automatic logic [3:0] len_of(input logic [urx_pkg::CW_WIDTH-1:0] cw);
        len_of = urx_pkg::MIN_LEN + {2'h0, cw[urx_pkg::CW_LEN_HI], cw[urx_pkg::CW_LEN_LO]};
    endfunction : len_of

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    // Even select expects zero ones overall, odd expects one
    function automatic logic par_err(input logic [urx_pkg::CW_WIDTH-1:0] cw, input logic acc);
        par_err = ~cw[urx_pkg::CW_PAR_INH] & (acc ^ ~cw[urx_pkg::CW_EVEN_PAR]);
    endfunction : par_err

    // ==========================================================
    // Divider
    urx_tick_if tick_if ();

    urx_tick_gen u_tick_gen (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tick_if (tick_if)
    );

    // ==========================================================
    // Bus and software registers
    logic [urx_pkg::CW_WIDTH-1:0] staged_q, staged_d;
    logic [urx_pkg::CW_WIDTH-1:0] ctrl_q, ctrl_d;
    logic                         load_q, load_d;
    logic                         rclr_n_q, rclr_n_d;
    logic [15:0]                  divisor_q, divisor_d;
    logic [urx_pkg::EV_WIDTH-1:0] mask_q, mask_d;
    logic                         ack_q, ack_d;
    logic [31:0]                  rdata_q, rdata_d;
    logic                         req;
    logic                         wr_go;
    logic                         rd_status;

    assign req       = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_go     = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
    assign rd_status = wb_cyc_i & wb_stb_i & ack_q & ~wb_we_i & hit(wb_adr_i, urx_pkg::OFS_IRQ_STATUS);

    // Receiver state, declared early for the read mux
    urx_pkg::urx_state_t          state_q, state_d;
    logic [3:0]                   tcnt_q, tcnt_d;
    logic [3:0]                   bidx_q, bidx_d;
    logic [7:0]                   shreg_q, shreg_d;
    logic                         par_acc_q, par_acc_d;
    logic                         stop_q, stop_d;
    logic                         pend_q, pend_d;
    logic [7:0]                   buf_q, buf_d;
    logic                         dr_q, dr_d;
    logic                         oe_q, oe_d;
    logic                         fe_q, fe_d;
    logic                         pe_q, pe_d;
    logic [urx_pkg::EV_WIDTH-1:0] sticky_q, sticky_d;
    logic [urx_pkg::EV_WIDTH-1:0] ev;

    always_comb begin
        staged_d  = staged_q;
        load_d    = load_q;
        rclr_n_d  = rclr_n_q;
        divisor_d = divisor_q;
        mask_d    = mask_q;
        ack_d     = req;
        rdata_d   = rdata_q;
        if (wr_go && wb_sel_i[0]) begin
            if (hit(wb_adr_i, urx_pkg::OFS_CTRL_WORD)) begin
                staged_d = wb_dat_i[urx_pkg::CW_WIDTH-1:0];
                load_d   = wb_dat_i[urx_pkg::CW_LOAD];
            end
            if (hit(wb_adr_i, urx_pkg::OFS_HOST_CTRL)) begin
                rclr_n_d = wb_dat_i[urx_pkg::HC_READY_CLEAR_N];
            end
            if (hit(wb_adr_i, urx_pkg::OFS_DIVISOR)) begin
                divisor_d[7:0] = wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, urx_pkg::OFS_IRQ_MASK)) begin
                mask_d = wb_dat_i[urx_pkg::EV_WIDTH-1:0];
            end
        end
        if (wr_go && wb_sel_i[1] && hit(wb_adr_i, urx_pkg::OFS_DIVISOR)) begin
            divisor_d[15:8] = wb_dat_i[15:8];
        end
        if (req) begin
            rdata_d = 32'h0000_0000;
            case (wb_adr_i[7:2])
                urx_pkg::OFS_CTRL_WORD[7:2]:  rdata_d = {26'h0, load_q, ctrl_q};
                urx_pkg::OFS_HOST_CTRL[7:2]:  rdata_d = {31'h0, rclr_n_q};
                urx_pkg::OFS_DIVISOR[7:2]:    rdata_d = {16'h0, divisor_q};
                urx_pkg::OFS_RX_BUFFER[7:2]:  rdata_d = {24'h0, buf_q};
                urx_pkg::OFS_FLAGS[7:2]:      rdata_d = {28'h0, pe_q, fe_q, oe_q, dr_q};
                urx_pkg::OFS_IRQ_STATUS[7:2]: rdata_d = {28'h0, sticky_q};
                urx_pkg::OFS_IRQ_MASK[7:2]:   rdata_d = {28'h0, mask_q};
                default:                      rdata_d = 32'h0000_0000;
            endcase
        end
        // Transparent while load is high, holds from its falling edge
        ctrl_d = load_q ? staged_q : ctrl_q;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            staged_q  <= urx_pkg::CW_RST;
            ctrl_q    <= urx_pkg::CW_RST;
            load_q    <= urx_pkg::LOAD_RST;
            rclr_n_q  <= urx_pkg::RCLR_N_RST;
            divisor_q <= urx_pkg::DIVISOR_RST;
            mask_q    <= urx_pkg::MASK_RST;
            ack_q     <= 1'b0;
            rdata_q   <= 32'h0000_0000;
        end else begin
            staged_q  <= staged_d;
            ctrl_q    <= ctrl_d;
            load_q    <= load_d;
            rclr_n_q  <= rclr_n_d;
            divisor_q <= divisor_d;
            mask_q    <= mask_d;
            ack_q     <= ack_d;
            rdata_q   <= rdata_d;
        end
    end

    assign tick_if.divisor = divisor_q;
    assign wb_ack_o        = ack_q;
    assign wb_dat_o        = rdata_q;

    // ==========================================================
    // Receive engine
    always_comb begin
        state_d   = state_q;
        tcnt_d    = tcnt_q;
        bidx_d    = bidx_q;
        shreg_d   = shreg_q;
        par_acc_d = par_acc_q;
        stop_d    = stop_q;
        pend_d    = pend_q;
        buf_d     = buf_q;
        dr_d      = dr_q;
        oe_d      = oe_q;
        fe_d      = fe_q;
        pe_d      = pe_q;
        ev        = '0;
        if (tick_if.tick) begin
            tcnt_d = tcnt_q + 4'h1;
            if (pend_q) begin
                pend_d        = 1'b0;
                dr_d          = 1'b1;
                fe_d          = ~stop_q;
                ev[urx_pkg::EV_CHAR]    = 1'b1;
                ev[urx_pkg::EV_FRAMING] = ~stop_q;
            end
            case (state_q)
                urx_pkg::ST_HUNT: begin
                    // Low seen on a tick edge, up to one tick late
                    if (!rx_serial_in) begin
                        state_d = urx_pkg::ST_START;
                        tcnt_d  = 4'h0;
                    end
                end
                urx_pkg::ST_START: begin
                    if (tcnt_q == urx_pkg::START_CENTRE) begin
                        tcnt_d    = 4'h0;
                        bidx_d    = 4'h0;
                        shreg_d   = 8'h00;
                        par_acc_d = 1'b0;
                        state_d   = rx_serial_in ? urx_pkg::ST_HUNT : urx_pkg::ST_DATA;
                    end
                end
                urx_pkg::ST_DATA: begin
                    if (tcnt_q == urx_pkg::TICKS_PER_BIT) begin
                        shreg_d[bidx_q[2:0]] = rx_serial_in;
                        par_acc_d = par_acc_q ^ rx_serial_in;
                        bidx_d    = bidx_q + 4'h1;
                        if (bidx_q + 4'h1 == len_of(ctrl_q)) begin
                            state_d = ctrl_q[urx_pkg::CW_PAR_INH] ? urx_pkg::ST_STOP
                                                                  : urx_pkg::ST_PARITY;
                        end
                    end
                end
                urx_pkg::ST_PARITY: begin
                    if (tcnt_q == urx_pkg::TICKS_PER_BIT) begin
                        par_acc_d = par_acc_q ^ rx_serial_in;
                        state_d   = urx_pkg::ST_STOP;
                    end
                end
                urx_pkg::ST_STOP: begin
                    if (tcnt_q == urx_pkg::TICKS_PER_BIT) begin
                        buf_d   = shreg_q;
                        oe_d    = dr_q;
                        stop_d  = rx_serial_in;
                        pend_d  = 1'b1;
                        pe_d    = par_err(ctrl_q, par_acc_q);
                        ev[urx_pkg::EV_OVERRUN] = dr_q;
                        ev[urx_pkg::EV_PARITY]  = par_err(ctrl_q, par_acc_q);
                        state_d = urx_pkg::ST_HUNT;
                    end
                end
                default: begin
                    state_d = urx_pkg::ST_HUNT;
                end
            endcase
        end
        if (!rclr_n_q) begin
            dr_d = 1'b0;
        end
        if (ctrl_q[urx_pkg::CW_PAR_INH]) begin
            pe_d = 1'b0;
        end
        // New events win over the read clear
        sticky_d = (sticky_q & ~(rd_status ? rdata_q[urx_pkg::EV_WIDTH-1:0] : 4'h0)) | ev;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q   <= urx_pkg::ST_HUNT;
            tcnt_q    <= 4'h0;
            bidx_q    <= 4'h0;
            shreg_q   <= 8'h00;
            par_acc_q <= 1'b0;
            stop_q    <= 1'b1;
            pend_q    <= 1'b0;
            buf_q     <= 8'h00;
            dr_q      <= 1'b0;
            oe_q      <= 1'b0;
            fe_q      <= 1'b0;
            pe_q      <= 1'b0;
            sticky_q  <= 4'h0;
        end else begin
            state_q   <= state_d;
            tcnt_q    <= tcnt_d;
            bidx_q    <= bidx_d;
            shreg_q   <= shreg_d;
            par_acc_q <= par_acc_d;
            stop_q    <= stop_d;
            pend_q    <= pend_d;
            buf_q     <= buf_d;
            dr_q      <= dr_d;
            oe_q      <= oe_d;
            fe_q      <= fe_d;
            pe_q      <= pe_d;
            sticky_q  <= sticky_d;
        end
    end

    // ==========================================================
    // Outputs
    assign rx_buffer    = buf_q;
    assign data_ready   = dr_q;
    assign overrun_flag = oe_q;
    assign framing_flag = fe_q;
    assign parity_flag  = pe_q;
    assign irq          = |(sticky_q & mask_q);

endmodule : urx_receiver

// ===== dv/urx_rx_sva.sv
/* Port checker for the serial receiver.
   Assumes binding to urx_receiver, one clock clk_sys, async active-high reset. */
`timescale 1ns/10ps

module urx_rx_sva (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        rx_serial_in,
    input wire logic [7:0]  rx_buffer,
    input wire logic        data_ready,
    input wire logic        overrun_flag,
    input wire logic        framing_flag,
    input wire logic        parity_flag,
    input wire logic        irq
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    rdy_clear_a: assert property ((wb_ack_o && wb_we_i && wb_sel_i[0] && !wb_dat_i[0]
        && wb_adr_i[7:2] == urx_pkg::OFS_HOST_CTRL[7:2]) |-> ##2 !data_ready)
        else $error("data ready not cleared");
    flag_read_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i[7:2] == urx_pkg::OFS_FLAGS[7:2])
        |-> wb_dat_o == {28'h0, $past(parity_flag), $past(framing_flag), $past(overrun_flag), $past(data_ready)})
        else $error("flag read mismatch");
    buf_move_a: assert property ($changed(rx_buffer) |-> !data_ready || overrun_flag)
        else $error("buffer moved over unread data");
    ovr_rdy_a: assert property ($rose(overrun_flag) |-> $past(data_ready))
        else $error("overrun without pending data");
    frm_rdy_a: assert property ($rose(framing_flag) |-> data_ready)
        else $error("framing set apart from data ready");
    par_move_a: assert property ($rose(parity_flag) |-> !data_ready || overrun_flag)
        else $error("parity set outside transfer");

    cover property ($rose(data_ready));
    cover property ($rose(overrun_flag));
    cover property ($rose(framing_flag));
    cover property ($rose(irq));
endmodule : urx_rx_sva

// ===== dv/urx_line_model.sv
/* Remote serial transmitter driving the receive line, sixteen clocks a bit.
   Assumes the receiver divisor is 0, so one sample tick per clk_sys. */
`timescale 1ns/10ps

module urx_line_model (
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic [7:0] char_i,
    input  wire logic [3:0] nbits,
    input  wire logic       par_en,
    input  wire logic       even,
    input  wire logic       bad_par,
    input  wire logic       bad_stop,
    input  wire logic       glitch,
    output logic            line,
    output logic            busy
);
    logic [10:0] frame;
    logic        par;
    int          k;

    // ==========================================================
    // Frame sender
    initial begin
        line = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (glitch) begin
                line <= 1'b0;
                repeat (4) @(posedge clk_sys);
                line <= 1'b1;
            end else if (go) begin
                frame = '1;
                frame[0] = 1'b0;
                par = !even;
                for (k = 0; k < nbits; k++) begin
                    frame[1+k] = char_i[k];
                    par = par ^ char_i[k];
                end
                k = 1 + nbits;
                if (par_en) begin
                    frame[k] = par ^ bad_par;
                    k++;
                end
                frame[k] = !bad_stop;
                busy <= 1'b1;
                for (int j = 0; j <= k; j++) begin
                    line <= frame[j];
                    repeat (16) @(posedge clk_sys);
                end
                line <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule : urx_line_model

// ===== dv/tb.sv
/* Self-checking bench for the serial receiver.
   Assumes urx_receiver, urx_line_model and urx_rx_sva are compiled alongside. */
`timescale 1ns/10ps

module tb;
    logic        clk_sys = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, line, busy;
    logic [7:0]  adr = 8'h00, rx_buffer, ch = 8'h00;
    logic [3:0]  sel = 4'h0, nb = 4'h8;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic        rdy, ovr, frm, par, go = 1'b0, pe = 1'b0, ev = 1'b0, bp = 1'b0, bs = 1'b0, gl = 1'b0;
    int          err_count = 0, checked = 0;

    always #4 clk_sys = ~clk_sys;

    urx_receiver dut_u (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .rx_serial_in(line), .rx_buffer(rx_buffer), .data_ready(rdy), .overrun_flag(ovr),
        .framing_flag(frm), .parity_flag(par), .irq(irq));
    urx_line_model line_u (.clk_sys(clk_sys), .go(go), .char_i(ch), .nbits(nb), .par_en(pe), .even(ev),
        .bad_par(bp), .bad_stop(bs), .glitch(gl), .line(line), .busy(busy));

    // ==========================================================
    // Shared tasks
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'h3;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 50);
        chk({31'h0, ack}, 32'h1);
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_sys);
    endtask : xfer

    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    task cfg(input logic [1:0] len, input logic inh, input logic even);
        xfer(1'b1, urx_pkg::OFS_CTRL_WORD, {26'h0, 1'b1, 1'b0, even, inh, len});
    endtask : cfg

    task clr();
        xfer(1'b1, urx_pkg::OFS_HOST_CTRL, 32'h0);
        xfer(1'b1, urx_pkg::OFS_HOST_CTRL, 32'h1);
    endtask : clr

    task send(input logic [7:0] c, input logic [3:0] n, input logic p, input logic e, input logic b, input logic s);
        int w;
        ch <= c; nb <= n; pe <= p; ev <= e; bp <= b; bs <= s; go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        w = 0;
        do begin @(posedge clk_sys); w++; end while (busy !== 1'b0 && w < 400);
        chk({31'h0, busy}, 32'h0);
    endtask : send

    // ==========================================================
    // Scenarios
    task t_regs();
        rd(urx_pkg::OFS_CTRL_WORD, 32'h20);
        rd(urx_pkg::OFS_DIVISOR, 32'h43);
        rd(urx_pkg::OFS_IRQ_MASK, 32'h0);
        rd(8'h1c, 32'h0);
        xfer(1'b1, urx_pkg::OFS_DIVISOR, 32'h0);
        rd(urx_pkg::OFS_DIVISOR, 32'h0);
    endtask : t_regs

    task t_len();
        for (int l = 0; l < 4; l++) begin
            cfg(l[1:0], 1'b1, 1'b0);
            send(8'ha5, 4'(5 + l), 1'b0, 1'b0, 1'b0, 1'b0);
            chk({24'h0, rx_buffer}, {24'h0, 8'ha5 & (8'hff >> (3 - l))});
            rd(urx_pkg::OFS_FLAGS, 32'h1);
            clr();
        end
    endtask : t_len

    task t_par();
        for (int i = 0; i < 4; i++) begin
            cfg(2'h3, 1'b0, i[0]);
            send(8'h6b, 4'h8, 1'b1, i[0], i[1], 1'b0);
            rd(urx_pkg::OFS_FLAGS, {28'h0, i[1], 3'b001});
            chk({31'h0, par}, {31'h0, i[1]});
            rd(urx_pkg::OFS_IRQ_STATUS, {28'h0, i[1], 3'b001});
            clr();
        end
    endtask : t_par

    task t_latch();
        cfg(2'h3, 1'b1, 1'b0);
        xfer(1'b1, urx_pkg::OFS_CTRL_WORD, 32'h07);
        xfer(1'b1, urx_pkg::OFS_CTRL_WORD, 32'h00);
        rd(urx_pkg::OFS_CTRL_WORD, 32'h07);
        send(8'hc3, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0);
        chk({24'h0, rx_buffer}, 32'hc3);
        clr();
    endtask : t_latch

    task t_frm_irq();
        cfg(2'h3, 1'b1, 1'b0);
        xfer(1'b0, urx_pkg::OFS_IRQ_STATUS, 32'h0);
        xfer(1'b1, urx_pkg::OFS_IRQ_MASK, 32'h0);
        send(8'h3c, 4'h8, 1'b0, 1'b0, 1'b0, 1'b1);
        chk({31'h0, frm}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, urx_pkg::OFS_IRQ_MASK, 32'h4);
        chk({31'h0, irq}, 32'h1);
        rd(urx_pkg::OFS_IRQ_STATUS, 32'h5);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, urx_pkg::OFS_IRQ_MASK, 32'h0);
        clr();
    endtask : t_frm_irq

    task t_ovr();
        send(8'h11, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0);
        send(8'h22, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0);
        chk({24'h0, rx_buffer}, 32'h22);
        rd(urx_pkg::OFS_FLAGS, 32'h3);
        chk({31'h0, ovr}, 32'h1);
        rd(urx_pkg::OFS_IRQ_STATUS, 32'h3);
        xfer(1'b1, urx_pkg::OFS_HOST_CTRL, 32'h0);
        @(posedge clk_sys);
        chk({31'h0, rdy}, 32'h0);
        xfer(1'b1, urx_pkg::OFS_HOST_CTRL, 32'h1);
        send(8'h33, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(urx_pkg::OFS_FLAGS, 32'h1);
        clr();
    endtask : t_ovr

    task t_glitch();
        xfer(1'b0, urx_pkg::OFS_IRQ_STATUS, 32'h0);
        gl <= 1'b1;
        @(posedge clk_sys);
        gl <= 1'b0;
        repeat (300) @(posedge clk_sys);
        chk({31'h0, rdy}, 32'h0);
        rd(urx_pkg::OFS_IRQ_STATUS, 32'h0);
    endtask : t_glitch

    // ==========================================================
    // Run control
    task test_done();
        $display("Checks %0d, errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_len();
        t_par();
        t_latch();
        t_frm_irq();
        t_ovr();
        t_glitch();
        test_done();
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        test_done();
    end
endmodule : tb

bind urx_receiver urx_rx_sva chk_u (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_serial_in(rx_serial_in), .rx_buffer(rx_buffer), .data_ready(data_ready),
    .overrun_flag(overrun_flag), .framing_flag(framing_flag), .parity_flag(parity_flag), .irq(irq));
